// file: slp_regs.sv
// Serial link parameter, status and pair enable registers on APB
`timescale 1ns/1ps

// Notes on behaviour
// - Identifier sent in second alignment multiframe
// - Comma select: 0 K28.7, 1 K28.1, 2 K28.5
// - Comma inserted only in 8B/10B modes
// - Status bit 6 shows link up
// - Status bit 5 is sync request level
// - Status bit 4 set on clock realignment
// - Status bit 3 set by first sysref
// - Realigned and multiframe_phase_set_flag cleared by writing one
// - Status bit 2 shows serializer PLL lock
// - Status bit 0 sampling PLL lock
// - Pair enable resets to both pairs on
// - One path mode disables channels B, C, D
// - One pair off halves converters and lanes, lanes rounded up
module slp_regs
   import slp_pkg::*;
#(
   parameter int unsigned CNT_W = 5
) (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic [SLP_AW-1:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic pready,
   output logic [31:0] prdata,
   output logic pslverr,
   input wire logic link_up,
   input wire logic sync_n_pin,
   input wire logic sysref_realign,
   input wire logic sysref_event,
   input wire logic serializer_pll_lock_pin,
   input wire logic sampling_pll_lock_pin,
   input wire logic [CNT_W-1:0] nominal_converters,
   input wire logic [CNT_W-1:0] nominal_lanes,
   output logic [7:0] link_identifier_value,
   output logic [1:0] frame_end_comma_sel,
   output logic [7:0] frame_end_comma_code,
   output logic comma_insert_en,
   output logic serial_link_enable,
   output logic encoding_8b10b,
   output logic first_pair_enable,
   output logic second_pair_enable,
   output logic one_path_mode,
   output logic [3:0] channel_enable,
   output logic [CNT_W-1:0] link_converters,
   output logic [CNT_W-1:0] link_lanes,
   output logic lane_tail_pad,
   output logic irq
);

   // ==========================================
   // Pin synchronisers: sync, serializer lock, sampling lock
   logic [2:0] pin_s1;
   logic [2:0] pin_s2;

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         pin_s1 <= 3'h0;
         pin_s2 <= 3'h0;
      end else begin
         pin_s1 <= {sync_n_pin, serializer_pll_lock_pin, sampling_pll_lock_pin};
         pin_s2 <= pin_s1;
      end
   end

   // ==========================================
   // APB slave
   logic setup;
   logic hit;
   logic wr;
   logic [31:0] rd_mux;
   logic [7:0] status;
   logic realigned;
   logic multiframe_phase_set_flag;
   logic [1:0] irq_mask;

   assign setup = psel & ~penable;
   assign wr = psel & penable & pready & pwrite & ~pslverr;

   always_comb begin
      hit = 1'b1;
      rd_mux = 32'h0000_0000;
      unique case (paddr)
         ADDR_LINK_ID: rd_mux[7:0] = link_identifier_value;
         ADDR_COMMA: rd_mux[1:0] = frame_end_comma_sel;
         ADDR_STATUS: rd_mux[7:0] = status;
         ADDR_PAIR: rd_mux[2:0] = {one_path_mode, second_pair_enable, first_pair_enable};
         ADDR_CTRL: rd_mux[1:0] = {encoding_8b10b, serial_link_enable};
         ADDR_MASK: rd_mux[1:0] = irq_mask;
         default: hit = 1'b0;
      endcase
   end

   // No wait state: ready in the first access cycle
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         pready <= 1'b0;
         prdata <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else begin
         pready <= setup;
         pslverr <= setup & ~hit;
         if (setup) begin
            prdata <= pwrite ? 32'h0000_0000 : rd_mux;
         end
      end
   end

   // ==========================================
   // Writable registers
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         link_identifier_value <= RST_LINK_ID;
         frame_end_comma_sel <= RST_COMMA;
         {one_path_mode, second_pair_enable, first_pair_enable} <= RST_PAIR;
         {encoding_8b10b, serial_link_enable} <= RST_CTRL;
         irq_mask <= RST_MASK;
      end else if (wr) begin
         unique case (paddr)
            ADDR_LINK_ID: link_identifier_value <= pwdata[7:0];
            ADDR_COMMA: frame_end_comma_sel <= pwdata[1:0];
            ADDR_PAIR: begin
               first_pair_enable <= pwdata[PE_FIRST];
               second_pair_enable <= pwdata[PE_SECOND];
               one_path_mode <= pwdata[PE_ONE_PATH];
            end
            ADDR_CTRL: begin
               serial_link_enable <= pwdata[CT_LINK_EN];
               encoding_8b10b <= pwdata[CT_8B10B];
            end
            ADDR_MASK: irq_mask <= {pwdata[ST_REALIGN], pwdata[ST_ALIGN]};
            default: begin
            end
         endcase
      end
   end

   // ==========================================
   // Sticky alignment flags, set wins over clear
   logic clr_realign;
   logic clr_align;
   logic link_en_q;
   logic armed;
   logic arm_now;

   assign clr_realign = wr & (paddr == ADDR_STATUS) & pwdata[ST_REALIGN];
   assign clr_align = wr & (paddr == ADDR_STATUS) & pwdata[ST_ALIGN];
   assign arm_now = armed | (serial_link_enable & ~link_en_q);

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         realigned <= 1'b0;
      end else if (sysref_realign) begin
         realigned <= 1'b1;
      end else if (clr_realign) begin
         realigned <= 1'b0;
      end
   end

   // Armed from link enable until the first sysref
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         link_en_q <= 1'b0;
         armed <= 1'b0;
      end else begin
         link_en_q <= serial_link_enable;
         if (sysref_event | ~serial_link_enable) begin
            armed <= 1'b0;
         end else if (serial_link_enable & ~link_en_q) begin
            armed <= 1'b1;
         end
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         multiframe_phase_set_flag <= 1'b0;
      end else if (arm_now & sysref_event) begin
         multiframe_phase_set_flag <= 1'b1;
      end else if (clr_align) begin
         multiframe_phase_set_flag <= 1'b0;
      end
   end

   // ==========================================
   // Live status bits, no write path
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         status <= 8'h00;
      end else begin
         status <= 8'h00;
         status[ST_LINK_UP] <= link_up;
         status[ST_SYNC] <= pin_s2[2];
         status[ST_REALIGN] <= realigned;
         status[ST_ALIGN] <= multiframe_phase_set_flag;
         status[ST_SPLL] <= pin_s2[1];
         status[ST_CPLL] <= pin_s2[0];
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         irq <= 1'b0;
      end else begin
         irq <= |({realigned, multiframe_phase_set_flag} & irq_mask);
      end
   end

   // ==========================================
   // Comma code for the link encoder
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         frame_end_comma_code <= K28_7;
         comma_insert_en <= 1'b0;
      end else begin
         comma_insert_en <= encoding_8b10b && (frame_end_comma_sel != 2'h3);
         unique case (frame_end_comma_sel)
            SEL_K28_7: frame_end_comma_code <= K28_7;
            SEL_K28_1: frame_end_comma_code <= K28_1;
            SEL_K28_5: frame_end_comma_code <= K28_5;
            default: frame_end_comma_code <= K28_7;
         endcase
      end
   end

   // ==========================================
   // Channel enables and link size scaling
   logic both_pairs;
   logic [CNT_W:0] lanes_up;

   assign both_pairs = first_pair_enable & second_pair_enable;
   assign lanes_up = {1'b0, nominal_lanes} + {{CNT_W{1'b0}}, 1'b1};

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         channel_enable <= 4'h0;
         link_converters <= '0;
         link_lanes <= '0;
         lane_tail_pad <= 1'b0;
      end else begin
         channel_enable[0] <= first_pair_enable;
         channel_enable[1] <= first_pair_enable & ~one_path_mode;
         channel_enable[2] <= second_pair_enable & ~one_path_mode;
         channel_enable[3] <= second_pair_enable & ~one_path_mode;
         if (both_pairs) begin
            link_converters <= nominal_converters;
            link_lanes <= nominal_lanes;
            lane_tail_pad <= 1'b0;
         end else begin
            link_converters <= nominal_converters >> 1;
            link_lanes <= lanes_up[CNT_W:1];
            lane_tail_pad <= nominal_lanes[0];
         end
      end
   end

   // ==========================================
   // Checks
   property p_link_up;
      @(posedge core_clk) disable iff (!rst_n)
      1'b1 |=> status[ST_LINK_UP] == $past(link_up);
   endproperty
   a_link_up: assert property (p_link_up) else $error("link up bit wrong");

   property p_sync;
      @(posedge core_clk) disable iff (!rst_n)
      !sync_n_pin [*3] |=> !status[ST_SYNC];
   endproperty
   a_sync: assert property (p_sync) else $error("sync bit not low");

   property p_realign_set;
      @(posedge core_clk) disable iff (!rst_n)
      sysref_realign |=> ##1 status[ST_REALIGN];
   endproperty
   a_realign_set: assert property (p_realign_set) else $error("realign not flagged");

   property p_align_cause;
      @(posedge core_clk) disable iff (!rst_n)
      $rose(multiframe_phase_set_flag) |-> $past(sysref_event) &&
         ($past(armed) || ($past(serial_link_enable) && !$past(link_en_q)));
   endproperty
   a_align_cause: assert property (p_align_cause) else $error("multiframe_phase_set_flag without first sysref");

   property p_sticky;
      @(posedge core_clk) disable iff (!rst_n)
      realigned && !clr_realign |=> realigned;
   endproperty
   a_sticky: assert property (p_sticky) else $error("realign flag dropped");

   property p_realign_clear;
      @(posedge core_clk) disable iff (!rst_n)
      clr_realign && !sysref_realign |=> !realigned;
   endproperty
   a_realign_clear: assert property (p_realign_clear) else $error("realign flag not cleared");

   property p_spll;
      @(posedge core_clk) disable iff (!rst_n)
      serializer_pll_lock_pin [*3] |=> status[ST_SPLL];
   endproperty
   a_spll: assert property (p_spll) else $error("serializer lock not shown");

   property p_cpll;
      @(posedge core_clk) disable iff (!rst_n)
      !sampling_pll_lock_pin [*3] |=> !status[ST_CPLL];
   endproperty
   a_cpll: assert property (p_cpll) else $error("sampling lock stale");

   property p_comma;
      @(posedge core_clk) disable iff (!rst_n)
      encoding_8b10b && frame_end_comma_sel == SEL_K28_1 |=>
         comma_insert_en && frame_end_comma_code == K28_1;
   endproperty
   a_comma: assert property (p_comma) else $error("comma code wrong");

   property p_one_path;
      @(posedge core_clk) disable iff (!rst_n)
      one_path_mode |=> channel_enable[3:1] == 3'h0;
   endproperty
   a_one_path: assert property (p_one_path) else $error("channels on in one path mode");

   property p_halve;
      @(posedge core_clk) disable iff (!rst_n)
      !both_pairs |=> link_converters == ($past(nominal_converters) >> 1) &&
         link_lanes == ($past(nominal_lanes) >> 1) + CNT_W'($past(nominal_lanes[0])) &&
         lane_tail_pad == $past(nominal_lanes[0]);
   endproperty
   a_halve: assert property (p_halve) else $error("lane count not halved");

   property p_no_8b10b;
      @(posedge core_clk) disable iff (!rst_n)
      !encoding_8b10b |=> !comma_insert_en;
   endproperty
   a_no_8b10b: assert property (p_no_8b10b) else $error("comma outside 8b10b");

endmodule

// file: slp_pkg.sv
// Constants for the serial link parameter and status registers
package slp_pkg;

   // ==========================================
   // Register indices and byte addresses
   localparam int unsigned SLP_AW = 12;
   localparam logic [9:0] IDX_LINK_ID = 10'h206;
   localparam logic [9:0] IDX_COMMA = 10'h207;
   localparam logic [9:0] IDX_STATUS = 10'h208;
   localparam logic [9:0] IDX_PAIR = 10'h209;
   localparam logic [9:0] IDX_CTRL = 10'h20a;
   localparam logic [9:0] IDX_MASK = 10'h20b;
   localparam logic [11:0] ADDR_LINK_ID = {IDX_LINK_ID, 2'b00};
   localparam logic [11:0] ADDR_COMMA = {IDX_COMMA, 2'b00};
   localparam logic [11:0] ADDR_STATUS = {IDX_STATUS, 2'b00};
   localparam logic [11:0] ADDR_PAIR = {IDX_PAIR, 2'b00};
   localparam logic [11:0] ADDR_CTRL = {IDX_CTRL, 2'b00};
   localparam logic [11:0] ADDR_MASK = {IDX_MASK, 2'b00};

   // ==========================================
   // Status field positions
   localparam int unsigned ST_LINK_UP = 6;
   localparam int unsigned ST_SYNC = 5;
   localparam int unsigned ST_REALIGN = 4;
   localparam int unsigned ST_ALIGN = 3;
   localparam int unsigned ST_SPLL = 2;
   localparam int unsigned ST_CPLL = 0;

   // ==========================================
   // Pair enable and control field positions
   localparam int unsigned PE_FIRST = 0;
   localparam int unsigned PE_SECOND = 1;
   localparam int unsigned PE_ONE_PATH = 2;
   localparam int unsigned CT_LINK_EN = 0;
   localparam int unsigned CT_8B10B = 1;

   // ==========================================
   // Reset values
   localparam logic [7:0] RST_LINK_ID = 8'h00;
   localparam logic [1:0] RST_COMMA = 2'h0;
   localparam logic [2:0] RST_PAIR = 3'h3;
   localparam logic [1:0] RST_CTRL = 2'h0;
   localparam logic [1:0] RST_MASK = 2'h0;

   // ==========================================
   // Frame end comma selections and K codes
   localparam logic [1:0] SEL_K28_7 = 2'h0;
   localparam logic [1:0] SEL_K28_1 = 2'h1;
   localparam logic [1:0] SEL_K28_5 = 2'h2;
   localparam logic [7:0] K28_7 = 8'hfc;
   localparam logic [7:0] K28_1 = 8'h3c;
   localparam logic [7:0] K28_5 = 8'hbc;

endpackage

// file: slp_rx_model.sv
// Behavioural link receiver that drives the sync request and link up
`timescale 1ns/1ps

module slp_rx_model (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic start,
   output logic sync_n_pin,
   output logic link_up
);
   logic [2:0] cnt;

   // ==========================================
   // Sync request held low until code groups settle
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt <= 3'h0;
         sync_n_pin <= 1'b0;
         link_up <= 1'b0;
      end else if (!start) begin
         cnt <= 3'h0;
         sync_n_pin <= 1'b0;
         link_up <= 1'b0;
      end else if (cnt != 3'h4) begin
         cnt <= cnt + 3'h1;
      end else begin
         sync_n_pin <= 1'b1;
         link_up <= 1'b1;
      end
   end
endmodule

// file: slp_regs_tb.sv
// Self-checking testbench for the serial link register bank
`timescale 1ns/1ps

module slp_regs_tb;
   import slp_pkg::*;
   logic core_clk, rst_n, psel, penable, pwrite, pready, pslverr, sref_re, sref_ev, spll, cpll, start;
   logic sync_n, lup, irq, pad, ins, len, enc, pe1, pe2, one, err;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [7:0] lid, code;
   logic [1:0] sel;
   logic [3:0] chen;
   logic [4:0] lconv, llanes;
   int error_cnt, n_tests, cyc;
   logic [7:0] ktab [4] = '{K28_7, K28_1, K28_5, K28_7};

   slp_regs u_dut (.core_clk(core_clk), .rst_n(rst_n), .paddr(paddr), .psel(psel), .penable(penable),
      .pwrite(pwrite), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
      .link_up(lup), .sync_n_pin(sync_n), .sysref_realign(sref_re), .sysref_event(sref_ev),
      .serializer_pll_lock_pin(spll), .sampling_pll_lock_pin(cpll), .nominal_converters(5'h04),
      .nominal_lanes(5'h05), .link_identifier_value(lid), .frame_end_comma_sel(sel),
      .frame_end_comma_code(code), .comma_insert_en(ins), .serial_link_enable(len), .encoding_8b10b(enc),
      .first_pair_enable(pe1), .second_pair_enable(pe2), .one_path_mode(one), .channel_enable(chen),
      .link_converters(lconv), .link_lanes(llanes), .lane_tail_pad(pad), .irq(irq));
   slp_rx_model u_rx (.core_clk(core_clk), .rst_n(rst_n), .start(start), .sync_n_pin(sync_n), .link_up(lup));

   always #50 core_clk = ~core_clk;

   // ==========================================
   // Verdict, comparison and bus tasks
   task report_and_stop();
      $display("mismatches %0d comparisons %0d", error_cnt, n_tests);
      if (error_cnt == 0 && n_tests > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask

   task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[ERR] %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task xfer(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge core_clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      do @(posedge core_clk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task rchk(input string name, input logic [11:0] a, input logic [31:0] exp);
      xfer(1'b0, a, 32'h0000_0000);
      chk(name, rd, exp);
   endtask

   task wt(input int n);
      repeat (n) @(posedge core_clk);
   endtask

   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         error_cnt++;
         report_and_stop();
      end
   end

   // ==========================================
   // Main sequence
   initial begin
      core_clk = 0; rst_n = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
      sref_re = 0; sref_ev = 0; spll = 0; cpll = 0; start = 0; error_cnt = 0; n_tests = 0; cyc = 0;
      repeat (2) @(posedge core_clk);
      rst_n <= 1'b1;
      rchk("link_id", ADDR_LINK_ID, 32'h0000_0000);
      chk("slverr_ok", {31'h0, err}, 32'h0000_0000);
      rchk("comma", ADDR_COMMA, 32'h0000_0000);
      rchk("pair", ADDR_PAIR, 32'h0000_0003);
      chk("pair_pins", {29'h0, one, pe2, pe1}, 32'h0000_0003);
      // Identifier and comma written with the link disabled
      xfer(1'b1, ADDR_LINK_ID, 32'h0000_00a5);
      rchk("link_id", ADDR_LINK_ID, 32'h0000_00a5);
      chk("lid_out", {24'h0, lid}, 32'h0000_00a5);
      xfer(1'b1, ADDR_CTRL, 32'h0000_0002);
      for (int s = 0; s < 4; s++) begin
         xfer(1'b1, ADDR_COMMA, s);
         wt(2);
         chk("comma_code", {24'h0, code}, {24'h0, ktab[s]});
         chk("comma_sel", {30'h0, sel}, s);
         chk("comma_ins", {31'h0, ins}, (s != 3));
      end
      xfer(1'b1, ADDR_COMMA, 32'h0000_0003);
      rchk("comma_rsv", ADDR_COMMA, 32'h0000_0003);
      xfer(1'b1, ADDR_CTRL, 32'h0000_0000);
      xfer(1'b1, ADDR_COMMA, 32'h0000_0001);
      wt(2);
      chk("comma_ins_off", {31'h0, ins}, 32'h0000_0000);
      // Live status bits
      rchk("status_rst", ADDR_STATUS, 32'h0000_0000);
      spll <= 1'b1;
      wt(6);
      rchk("status_spll", ADDR_STATUS, 32'h0000_0004);
      cpll <= 1'b1;
      start <= 1'b1;
      wt(12);
      rchk("status_live", ADDR_STATUS, 32'h0000_0065);
      xfer(1'b1, ADDR_STATUS, 32'h0000_00ff);
      rchk("status_wr", ADDR_STATUS, 32'h0000_0065);
      // Realign event, mask and clear
      xfer(1'b1, ADDR_MASK, 32'h0000_0018);
      sref_re <= 1'b1;
      @(posedge core_clk);
      sref_re <= 1'b0;
      wt(3);
      chk("irq_realign", {31'h0, irq}, 32'h0000_0001);
      rchk("status_realign", ADDR_STATUS, 32'h0000_0075);
      xfer(1'b1, ADDR_MASK, 32'h0000_0000);
      wt(3);
      chk("irq_masked", {31'h0, irq}, 32'h0000_0000);
      rchk("status_held", ADDR_STATUS, 32'h0000_0075);
      xfer(1'b1, ADDR_STATUS, 32'h0000_0010);
      rchk("status_clr", ADDR_STATUS, 32'h0000_0065);
      // First sysref after link enable
      xfer(1'b1, ADDR_MASK, 32'h0000_0018);
      xfer(1'b1, ADDR_CTRL, 32'h0000_0003);
      for (int k = 0; k < 2; k++) begin
         sref_ev <= 1'b1;
         @(posedge core_clk);
         sref_ev <= 1'b0;
         wt(3);
         chk("irq_align", {31'h0, irq}, (k == 0));
         rchk("status_align", ADDR_STATUS, (k == 0) ? 32'h0000_006d : 32'h0000_0065);
         xfer(1'b1, ADDR_STATUS, 32'h0000_0008);
      end
      chk("ctrl_pins", {30'h0, enc, len}, 32'h0000_0003);
      // Pair enables with link disabled first
      xfer(1'b1, ADDR_CTRL, 32'h0000_0000);
      xfer(1'b1, ADDR_PAIR, 32'h0000_0001);
      wt(3);
      chk("chen_a", {28'h0, chen}, 32'h0000_0003);
      chk("conv_lanes", {21'h0, pad, lconv, llanes}, {21'h0, 1'b1, 5'h02, 5'h03});
      xfer(1'b1, ADDR_PAIR, 32'h0000_0005);
      wt(3);
      chk("chen_one", {28'h0, chen}, 32'h0000_0001);
      xfer(1'b1, ADDR_PAIR, 32'h0000_0003);
      wt(3);
      chk("chen_all", {28'h0, chen}, 32'h0000_000f);
      chk("conv_full", {21'h0, pad, lconv, llanes}, {21'h0, 1'b0, 5'h04, 5'h05});
      // Unmapped address
      xfer(1'b0, 12'h900, 32'h0000_0000);
      chk("unmapped", rd, 32'h0000_0000);
      chk("unmapped_err", {31'h0, err}, 32'h0000_0001);
      report_and_stop();
   end
endmodule
